// ===== dmc_pkg.sv
// shared constants and types for the mode-control front end
package dmc_pkg;

  // interface mode strap encoding (four strap levels, decoded off chip)
  typedef enum logic [1:0] {
    DMC_MODE_TWI = 2'b00,
    DMC_MODE_PAR = 2'b01,
    DMC_MODE_SPI0 = 2'b10,
    DMC_MODE_SPI1 = 2'b11
  } dmc_mode_t;

  // two-wire slave state machine
  typedef enum logic [3:0] {
    DMC_T_IDLE = 4'b0000,
    DMC_T_ADDR = 4'b0001,
    DMC_T_AACK = 4'b0010,
    DMC_T_REG = 4'b0011,
    DMC_T_RACK = 4'b0100,
    DMC_T_DATA = 4'b0101,
    DMC_T_DACK = 4'b0110,
    DMC_T_TX = 4'b0111,
    DMC_T_MACK = 4'b1000,
    DMC_T_IGN = 4'b1001
  } dmc_twi_st_t;

  // one register write towards the register file
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } dmc_wr_t;

  // two-wire addressing and index walk
  localparam logic [4:0] DMC_SLV_FIXED = 5'h13;
  localparam logic [7:0] DMC_IDX_TOP = 8'h4F;
  localparam logic [7:0] DMC_IDX_WRAP = 8'h40;
  localparam logic [7:0] DMC_REG_FIRST = 8'h40;
  localparam logic [7:0] DMC_REG_LAST = 8'h4F;
  localparam logic [3:0] DMC_BYTE_BITS = 4'h8;

  // three-wire framing
  localparam logic [4:0] DMC_WORD_BITS = 5'h10;
  localparam logic [4:0] DMC_XBYTE_BITS = 5'h08;
  localparam logic [3:0] DMC_MAX_XBYTES = 4'h9;
  localparam int DMC_OFS_SHIFT = 5;

  // strap capture after reset release (two sync stages plus one)
  localparam logic [1:0] DMC_STRAP_WAIT = 2'h2;

  // strap levels of the hardware mode pins
  localparam logic DMC_FMT_I2S = 1'b0;
  localparam logic DMC_FMT_LJ = 1'b1;

endpackage : dmc_pkg

// ===== dmc_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module dmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pins in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : dmc_sync
`default_nettype wire

// ===== dmc_top.sv
// mode-control front end: straps, three-wire write port, two-wire slave
// How it works
// - hardware mode, de-emphasis strap high enables 44.1 kHz de-emphasis, low disables.
// - hardware mode, format strap low selects I2S, high left-justified.
// - three-wire port timed by its own shift clock, not the audio clocks.
// - three-wire word is 16 bits: write bit 0, 7-bit address, 8 data, MSB first.
// - address bits 6 and 5 must equal the straps, else the word is ignored.
// - select low starts a write; data latched when select rises after clock 16.
// - up to 9 further data bytes while select stays low; select high ends.
// - two-wire side is a slave only, receiving and transmitting.
// - slave address 10011 plus two strap bits; other addresses ignored.
// - direction bit one means read, zero means write.
// - acknowledge slot low means accepted, high means not accepted.
// - write: address+W, register byte, data bytes, each acknowledged.
// - index advances by one after each valid data byte.
// - index past 4F wraps to 40.
// - undefined register addressed gets no acknowledge.
// - read: set index, repeated start, address+R, device sends byte, master NACKs.
// - interface strap taken only after reset release, then held.
// - strapped address bits 01/10/11 shift register addresses by 32/64/96.
`timescale 1ns/1ps
`default_nettype none
module dmc_top
  import dmc_pkg::*;
#(
  parameter logic [7:0] REG_FIRST = dmc_pkg::DMC_REG_FIRST,
  parameter logic [7:0] REG_LAST = dmc_pkg::DMC_REG_LAST
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // straps and shared control pins
  input wire logic [1:0] mode_strap_i,
  input wire logic ctl_serial_in_i,
  input wire logic ctl_shift_clock_i,
  input wire logic ctl_port_select_i,
  input wire logic addr_bit_fifth_i,
  // two-wire data pin driver (open drain)
  output logic sda_o,
  output logic sda_oe_o,
  // register file access
  output dmc_pkg::dmc_wr_t reg_wr_o,
  output logic [7:0] rd_index_o,
  input wire logic [7:0] rd_data_i,
  // resolved mode and hardware-mode controls
  output dmc_pkg::dmc_mode_t mode_o,
  output logic mode_valid_o,
  output logic deemph_en_o,
  output logic format_lj_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // index walk with wrap
  function automatic logic [7:0] next_idx(input logic [7:0] idx);
    next_idx = (idx == DMC_IDX_TOP) ? DMC_IDX_WRAP : 8'(idx + 8'h01);
  endfunction : next_idx

  // defined register window
  function automatic logic reg_defined(input logic [7:0] idx);
    reg_defined = (idx >= REG_FIRST) && (idx <= REG_LAST);
  endfunction : reg_defined

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and strap capture

  logic [5:0] pins_s;
  logic md_s, mc_s, ms_s, a5_s;
  logic [1:0] strap_s;

  dmc_sync #(.W(6)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({mode_strap_i, addr_bit_fifth_i, ctl_port_select_i, ctl_shift_clock_i, ctl_serial_in_i}),
    .q_o(pins_s)
  );

  assign md_s = pins_s[0];
  assign mc_s = pins_s[1];
  assign ms_s = pins_s[2];
  assign a5_s = pins_s[3];
  assign strap_s = pins_s[5:4];

  logic [1:0] wait_q;
  logic taken_q;
  dmc_mode_t mode_q;

  // take the mode strap once, a few cycles after reset release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= '0;
      taken_q <= 1'b0;
      mode_q <= DMC_MODE_TWI;
    end else if (!taken_q) begin
      if (wait_q == DMC_STRAP_WAIT) begin
        taken_q <= 1'b1;
        mode_q <= dmc_mode_t'(strap_s);
      end else begin
        wait_q <= 2'(wait_q + 2'h1);
      end
    end
  end

  wire is_par = taken_q && (mode_q == DMC_MODE_PAR);
  wire is_twi = taken_q && (mode_q == DMC_MODE_TWI);
  wire is_spi = taken_q && mode_q[1];

  assign mode_o = mode_q;
  assign mode_valid_o = taken_q;

  ////////////////////////////////////////////////////////////////////////////
  // hardware mode straps

  logic deemph_q, fmt_q;

  // pins follow straps directly, off in other modes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deemph_q <= 1'b0;
      fmt_q <= DMC_FMT_I2S;
    end else begin
      deemph_q <= is_par & md_s;
      fmt_q <= is_par ? (mc_s ? DMC_FMT_LJ : DMC_FMT_I2S) : DMC_FMT_I2S;
    end
  end

  assign deemph_en_o = deemph_q;
  assign format_lj_o = fmt_q;

  ////////////////////////////////////////////////////////////////////////////
  // shared edge detection on synchronised lines

  logic mc_prev_q, ms_prev_q, md_prev_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mc_prev_q <= 1'b0;
      ms_prev_q <= 1'b1;
      md_prev_q <= 1'b1;
    end else begin
      mc_prev_q <= mc_s;
      ms_prev_q <= ms_s;
      md_prev_q <= md_s;
    end
  end

  // shift clock found by sampling, never used as a clock
  wire mc_rise = mc_s & ~mc_prev_q;
  wire mc_fall = ~mc_s & mc_prev_q;
  wire ms_fall = ~ms_s & ms_prev_q;
  wire ms_rise = ms_s & ~ms_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // three-wire write port

  logic [15:0] s_sh_q;
  logic [4:0] s_bits_q;
  logic s_first_q, s_pend_q;
  logic [6:0] s_addr_q;
  logic [7:0] s_data_q;
  logic [3:0] s_xb_q;
  logic s_wr_q;
  logic [6:0] s_wr_addr_q;
  logic [7:0] s_wr_data_q;

  // word as it stands after the bit now arriving
  wire [15:0] s_word = {s_sh_q[14:0], md_s};
  wire [1:0] own_hi = {mode_q == DMC_MODE_SPI1, a5_s};
  wire [6:0] own_ofs = 7'({5'h00, own_hi} << DMC_OFS_SHIFT);
  wire s_match = (s_word[14:8] >= own_ofs) && (s_word[14:13] == own_hi);
  wire s_word_ok = !s_word[15] && s_match;
  wire s_word_end = !s_first_q && (5'(s_bits_q + 5'h01) == DMC_WORD_BITS);
  wire s_byte_end = s_first_q && (5'(s_bits_q + 5'h01) == DMC_XBYTE_BITS);
  wire s_shift = is_spi && !ms_s && mc_rise;

  // frame, count and latch the three-wire words
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_sh_q <= '0;
      s_bits_q <= '0;
      s_first_q <= 1'b0;
      s_pend_q <= 1'b0;
      s_addr_q <= '0;
      s_data_q <= '0;
      s_xb_q <= '0;
      s_wr_q <= 1'b0;
      s_wr_addr_q <= '0;
      s_wr_data_q <= '0;
    end else begin
      s_wr_q <= 1'b0;
      if (!is_spi || ms_fall) begin
        s_bits_q <= '0;
        s_first_q <= 1'b0;
        s_pend_q <= 1'b0;
        s_xb_q <= '0;
      end else if (ms_rise) begin
        s_wr_q <= s_pend_q;
        s_wr_addr_q <= s_addr_q;
        s_wr_data_q <= s_data_q;
        s_pend_q <= 1'b0;
        s_first_q <= 1'b0;
        s_bits_q <= '0;
      end else if (s_shift) begin
        s_sh_q <= s_word;
        if (s_word_end) begin
          s_first_q <= 1'b1;
          s_bits_q <= '0;
          s_addr_q <= s_word[14:8];
          s_data_q <= s_word[7:0];
          s_pend_q <= s_word_ok;
        end else if (s_byte_end) begin
          s_bits_q <= '0;
          s_wr_q <= s_pend_q;
          s_wr_addr_q <= s_addr_q;
          s_wr_data_q <= s_data_q;
          s_addr_q <= 7'(s_addr_q + 7'h01);
          s_data_q <= s_word[7:0];
          s_pend_q <= s_pend_q && (s_xb_q < DMC_MAX_XBYTES);
          if (s_xb_q < DMC_MAX_XBYTES) begin
            s_xb_q <= 4'(s_xb_q + 4'h1);
          end
        end else begin
          s_bits_q <= 5'(s_bits_q + 5'h01);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire slave

  dmc_twi_st_t t_st_q;
  logic [7:0] t_sh_q;
  logic [3:0] t_cnt_q;
  logic t_rw_q, t_oe_q;
  logic [7:0] t_idx_q;
  logic t_wr_q;
  logic [7:0] t_wr_addr_q, t_wr_data_q;

  // scl and sda share the shift clock and serial data pins
  wire t_start = is_twi && mc_s && mc_prev_q && md_prev_q && !md_s;
  wire t_stop = is_twi && mc_s && mc_prev_q && !md_prev_q && md_s;
  wire t_rise = is_twi && mc_rise;
  wire t_fall = is_twi && mc_fall;
  wire t_byte = (t_cnt_q == DMC_BYTE_BITS);
  wire [6:0] t_own = {DMC_SLV_FIXED, a5_s, ms_s};
  wire t_addr_hit = (t_sh_q[7:1] == t_own);
  wire t_rx = (t_st_q == DMC_T_ADDR) || (t_st_q == DMC_T_REG) || (t_st_q == DMC_T_DATA);

  // bus framing, acknowledge and byte transfer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_st_q <= DMC_T_IDLE;
      t_sh_q <= '0;
      t_cnt_q <= '0;
      t_rw_q <= 1'b0;
      t_oe_q <= 1'b0;
      t_idx_q <= DMC_IDX_WRAP;
      t_wr_q <= 1'b0;
      t_wr_addr_q <= '0;
      t_wr_data_q <= '0;
    end else begin
      t_wr_q <= 1'b0;
      if (!is_twi || t_stop) begin
        t_st_q <= DMC_T_IDLE;
        t_oe_q <= 1'b0;
      end else if (t_start) begin
        t_st_q <= DMC_T_ADDR; // repeated start lands here too
        t_cnt_q <= '0;
        t_oe_q <= 1'b0;
      end else if (t_rise) begin
        if (t_rx) begin
          t_sh_q <= {t_sh_q[6:0], md_s};
          t_cnt_q <= 4'(t_cnt_q + 4'h1);
        end else if (t_st_q == DMC_T_TX) begin
          t_cnt_q <= 4'(t_cnt_q + 4'h1);
        end else if (t_st_q == DMC_T_MACK) begin
          if (md_s) begin
            t_st_q <= DMC_T_IGN; // master not-acknowledge ends the read
          end else begin
            t_idx_q <= next_idx(t_idx_q);
            t_st_q <= DMC_T_AACK;
          end
        end
      end else if (t_fall) begin
        case (t_st_q)
          DMC_T_ADDR: begin
            if (t_byte) begin
              t_rw_q <= t_sh_q[0];
              t_oe_q <= t_addr_hit;
              t_st_q <= t_addr_hit ? DMC_T_AACK : DMC_T_IGN;
            end
          end
          DMC_T_REG: begin
            if (t_byte) begin
              t_oe_q <= reg_defined(t_sh_q);
              t_idx_q <= reg_defined(t_sh_q) ? t_sh_q : t_idx_q; // keep index inside window
              t_st_q <= reg_defined(t_sh_q) ? DMC_T_RACK : DMC_T_IGN;
            end
          end
          DMC_T_DATA: begin
            if (t_byte) begin
              t_oe_q <= reg_defined(t_idx_q);
              t_wr_q <= reg_defined(t_idx_q);
              t_wr_addr_q <= t_idx_q;
              t_wr_data_q <= t_sh_q;
              if (reg_defined(t_idx_q)) begin
                t_idx_q <= next_idx(t_idx_q);
              end
              t_st_q <= reg_defined(t_idx_q) ? DMC_T_DACK : DMC_T_IGN;
            end
          end
          DMC_T_AACK: begin
            t_cnt_q <= '0;
            if (t_rw_q) begin
              t_sh_q <= rd_data_i;
              t_oe_q <= !rd_data_i[7];
              t_st_q <= DMC_T_TX;
            end else begin
              t_oe_q <= 1'b0;
              t_st_q <= DMC_T_REG;
            end
          end
          DMC_T_RACK, DMC_T_DACK: begin
            t_oe_q <= 1'b0;
            t_cnt_q <= '0;
            t_st_q <= DMC_T_DATA;
          end
          DMC_T_TX: begin
            if (t_byte) begin
              t_oe_q <= 1'b0;
              t_st_q <= DMC_T_MACK;
            end else begin
              t_sh_q <= {t_sh_q[6:0], 1'b0};
              t_oe_q <= !t_sh_q[6];
            end
          end
          default: begin
            t_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = t_oe_q;
  assign rd_index_o = t_idx_q;

  ////////////////////////////////////////////////////////////////////////////
  // write port merge (only one interface is live at a time)

  assign reg_wr_o.valid = s_wr_q | t_wr_q;
  assign reg_wr_o.addr = s_wr_q ? {1'b0, s_wr_addr_q} : t_wr_addr_q;
  assign reg_wr_o.data = s_wr_q ? s_wr_data_q : t_wr_data_q;

endmodule : dmc_top
`default_nettype wire

// ===== dmc_top_assertions.sv
// assertion checker for the mode-control front end
`timescale 1ns/1ps
`default_nettype none
module dmc_top_assertions
  import dmc_pkg::*;
#(
  parameter logic [7:0] REG_FIRST = DMC_REG_FIRST,
  parameter logic [7:0] REG_LAST = DMC_REG_LAST
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic ctl_serial_in_i,
  input wire logic ctl_shift_clock_i,
  input wire logic addr_bit_fifth_i,
  // outputs
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire dmc_pkg::dmc_wr_t reg_wr_o,
  input wire logic [7:0] rd_index_o,
  input wire dmc_pkg::dmc_mode_t mode_o,
  input wire logic mode_valid_o,
  input wire logic deemph_en_o,
  input wire logic format_lj_o
);
  // captured mode decode
  wire logic par = mode_valid_o && mode_o == DMC_MODE_PAR;
  wire logic twi = mode_valid_o && mode_o == DMC_MODE_TWI;
  wire logic spi = mode_valid_o && mode_o[1];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  // a pull on the data line lasts through its slot
  sequence s_pull_start;
    $rose(sda_oe_o);
  endsequence
  sequence s_pull_hold;
    sda_oe_o [*4];
  endsequence
  a_slot_hold: assert property (s_pull_start |-> s_pull_hold) else $error("pull released too soon");
  a_pull_low_clk: assert property ($rose(sda_oe_o) || $fell(sda_oe_o) |->
    !ctl_shift_clock_i && !$past(ctl_shift_clock_i)) else $error("pull moved while clock high");
  a_open_drain: assert property (!sda_o) else $error("data pin driven high");
  a_pull_twi: assert property (sda_oe_o |-> twi) else $error("pull outside two-wire mode");
  a_wr_pulse: assert property (reg_wr_o.valid |=> !reg_wr_o.valid) else $error("write strobe too long");
  a_deemph_follow: assert property ((par && $stable(ctl_serial_in_i)) [*5] |->
    deemph_en_o == ctl_serial_in_i) else $error("de-emphasis not following pin");
  a_format_follow: assert property ((par && $stable(ctl_shift_clock_i)) [*5] |->
    format_lj_o == ctl_shift_clock_i) else $error("format not following pin");
  a_hw_idle: assert property (mode_valid_o && !par |-> !deemph_en_o && !format_lj_o) else $error("hw outputs set");
  a_mode_held: assert property (mode_valid_o |=> mode_valid_o && $stable(mode_o)) else $error("mode changed");
  a_twi_window: assert property (twi && reg_wr_o.valid |-> sda_oe_o &&
    reg_wr_o.addr >= REG_FIRST && reg_wr_o.addr <= REG_LAST) else $error("bad two-wire write");
  a_idx_window: assert property (twi |-> rd_index_o >= REG_FIRST && rd_index_o <= REG_LAST)
    else $error("index out of window");
  a_spi_match: assert property (spi && reg_wr_o.valid |->
    reg_wr_o.addr[7:5] == {1'b0, mode_o[0], addr_bit_fifth_i}) else $error("foreign three-wire write");
endmodule : dmc_top_assertions
`default_nettype wire

// ===== dmc_host.sv
// host model driving the shared control pins as bus master
`timescale 1ns/1ps
`default_nettype none
module dmc_host (
  // pacing clock
  input wire logic clk_i,
  // wired data line
  input wire logic sda_line_i,
  // control pins
  output logic md_o,
  output logic mc_o,
  output logic ms_o
);
  // idle levels
  initial begin
    md_o = 1'b1;
    mc_o = 1'b0;
    ms_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  // wait falling core edges
  task automatic hc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hc
  // three-wire: select low a shift period and a half before first rise
  task automatic open();
    ms_o = 1'b0;
    hc(8);
  endtask : open
  // eight bits msb first, data moved on falling shift clock
  task automatic sh(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      md_o = b[i];
      hc(4);
      mc_o = 1'b1;
      hc(4);
      mc_o = 1'b0;
    end
  endtask : sh
  // select high ends frame or burst; data line left changing
  task automatic fin();
    hc(2);
    ms_o = 1'b1;
    md_o = ~md_o;
    hc(8);
  endtask : fin
  // whole write word
  task automatic word(input logic [15:0] w);
    open();
    sh(w[15:8]);
    sh(w[7:0]);
    fin();
  endtask : word
  ////////////////////////////////////////////////////////////////
  // start or repeated start: data falls while clock high
  task automatic st();
    md_o = 1'b1;
    hc(4);
    mc_o = 1'b1;
    hc(4);
    md_o = 1'b0;
    hc(4);
    mc_o = 1'b0;
    hc(2);
  endtask : st
  // stop: data rises while clock high
  task automatic sp();
    md_o = 1'b0;
    hc(4);
    mc_o = 1'b1;
    hc(4);
    md_o = 1'b1;
    hc(8);
  endtask : sp
  // one clock pulse, line read while clock high
  task automatic bt(input logic b, output logic r);
    md_o = b;
    hc(2);
    mc_o = 1'b1;
    hc(4);
    r = sda_line_i;
    mc_o = 1'b0;
    hc(2);
  endtask : bt
  // byte msb first then ninth slot driven with ma
  task automatic xfer(input logic [7:0] b, input logic ma, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bt(b[i], r[i]);
    end
    bt(ma, ak);
  endtask : xfer
endmodule : dmc_host
`default_nettype wire

// ===== tb.sv
// self-checking testbench for the mode-control front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dmc_pkg::*;
  // clock, reset, straps and pins
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] mode_strap_i = 2'b00;
  logic addr_bit_fifth_i = 1'b0;
  logic md, mc, ms, sda_o, sda_oe_o, mode_valid_o, deemph_en_o, format_lj_o;
  dmc_wr_t reg_wr_o;
  dmc_mode_t mode_o;
  logic [7:0] rd_index_o;
  logic [7:0] r;
  logic ak;
  logic [15:0] wq[$];
  int miscompares = 0;
  int checks_done = 0;
  // {de-emphasis pin, format pin, expected de-emphasis, expected left-justified}
  logic [3:0] rows [4] = '{4'h0, 4'hA, 4'h5, 4'hF};
  // open-drain line with pull-up, register file stand-in
  wire logic sda_line = md & ~sda_oe_o;
  wire logic [7:0] rd_data = rd_index_o ^ 8'hA5;
  always #25 core_clk_i = ~core_clk_i;
  dmc_top u_dmc_top (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mode_strap_i(mode_strap_i),
    .ctl_serial_in_i(sda_line), .ctl_shift_clock_i(mc), .ctl_port_select_i(ms),
    .addr_bit_fifth_i(addr_bit_fifth_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_wr_o(reg_wr_o),
    .rd_index_o(rd_index_o), .rd_data_i(rd_data), .mode_o(mode_o), .mode_valid_o(mode_valid_o),
    .deemph_en_o(deemph_en_o), .format_lj_o(format_lj_o)
  );
  dmc_host u_dmc_host (.clk_i(core_clk_i), .sda_line_i(sda_line), .md_o(md), .mc_o(mc), .ms_o(ms));
  // collect register writes
  always @(posedge core_clk_i) if (reg_wr_o.valid === 1'b1) wq.push_back({reg_wr_o.addr, reg_wr_o.data});
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // reset with a strap level, then confirm capture
  task automatic rst(input dmc_mode_t m);
    @(negedge core_clk_i);
    rst_n_i = 1'b0;
    mode_strap_i = m;
    u_dmc_host.md_o = 1'b1;
    u_dmc_host.mc_o = 1'b0;
    u_dmc_host.ms_o = 1'b1;
    repeat (8) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (10) @(negedge core_clk_i);
    wq.delete();
    chk({13'h0, mode_valid_o, mode_o}, {13'h0, 1'b1, m});
  endtask : rst
  task automatic pop(input logic [15:0] e);
    chk(wq.size() > 0 ? wq.pop_front() : 16'hXXXX, e);
  endtask : pop
  task automatic tx(input logic [7:0] b, input logic ea);
    u_dmc_host.xfer(b, 1'b1, r, ak);
    chk({15'h0, ak}, {15'h0, ea});
  endtask : tx
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    final_report();
  end
  // main sequence
  initial begin
    rst(DMC_MODE_PAR);
    foreach (rows[i]) begin
      u_dmc_host.md_o = rows[i][3];
      u_dmc_host.mc_o = rows[i][2];
      repeat (6) @(negedge core_clk_i);
      chk({14'h0, deemph_en_o, format_lj_o}, {14'h0, rows[i][1:0]});
    end
    // strap change after capture is ignored
    mode_strap_i = DMC_MODE_TWI;
    repeat (6) @(negedge core_clk_i);
    chk({14'h0, mode_o}, {14'h0, DMC_MODE_PAR});
    // three-wire with address bits 01
    addr_bit_fifth_i = 1'b1;
    rst(DMC_MODE_SPI0);
    u_dmc_host.word(16'h2A5C);
    pop(16'h2A5C);
    // three-wire with address bits 10: good word, foreign word, read bit, short frame
    addr_bit_fifth_i = 1'b0;
    rst(DMC_MODE_SPI1);
    u_dmc_host.word(16'h523C);
    pop(16'h523C);
    u_dmc_host.word(16'h323C);
    u_dmc_host.word(16'hD23C);
    u_dmc_host.open();
    u_dmc_host.sh(8'h52);
    u_dmc_host.fin();
    chk(16'(wq.size()), 16'h0);
    // burst of ten extra bytes, only nine taken
    u_dmc_host.open();
    u_dmc_host.sh(8'h50);
    for (int k = 0; k < 11; k++) u_dmc_host.sh(8'(k));
    u_dmc_host.fin();
    for (int k = 0; k < 10; k++) pop({8'(8'h50 + k), 8'(k)});
    chk(16'(wq.size()), 16'h0);
    // two-wire: foreign address, write across wrap, undefined register, read
    rst(DMC_MODE_TWI);
    // slave address strap bits set to 10 so both pins leave their idle levels
    addr_bit_fifth_i = 1'b1;
    u_dmc_host.ms_o = 1'b0;
    u_dmc_host.st();
    tx(8'h9A, 1'b1);
    u_dmc_host.sp();
    u_dmc_host.st();
    tx(8'h9C, 1'b0);
    tx(8'h4E, 1'b0);
    for (int k = 1; k < 4; k++) tx(8'(k * 17), 1'b0);
    u_dmc_host.sp();
    pop(16'h4E11);
    pop(16'h4F22);
    pop(16'h4033);
    chk({8'h0, rd_index_o}, 16'h0041);
    u_dmc_host.st();
    tx(8'h9C, 1'b0);
    tx(8'h3F, 1'b1);
    u_dmc_host.sp();
    chk(16'(wq.size()), 16'h0);
    chk({8'h0, rd_index_o}, 16'h0041);
    u_dmc_host.st();
    tx(8'h9C, 1'b0);
    tx(8'h4F, 1'b0);
    u_dmc_host.st();
    tx(8'h9D, 1'b0);
    u_dmc_host.xfer(8'hFF, 1'b1, r, ak);
    chk({8'h0, r}, 16'h00EA);
    u_dmc_host.sp();
    chk({8'h0, rd_index_o}, 16'h004F);
    final_report();
  end
endmodule : tb
bind dmc_top dmc_top_assertions #(.REG_FIRST(REG_FIRST), .REG_LAST(REG_LAST)) u_dmc_top_assertions (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ctl_serial_in_i(ctl_serial_in_i),
  .ctl_shift_clock_i(ctl_shift_clock_i), .addr_bit_fifth_i(addr_bit_fifth_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .reg_wr_o(reg_wr_o), .rd_index_o(rd_index_o), .mode_o(mode_o),
  .mode_valid_o(mode_valid_o), .deemph_en_o(deemph_en_o), .format_lj_o(format_lj_o)
);
`default_nettype wire
